// File: rtl/lorc_defs.vh
`ifndef LORC_DEFS_VH
`define LORC_DEFS_VH

// --------------------------------------------------------------
// holding register addresses
// --------------------------------------------------------------
`define LORC_ADDR_MODE 16'h114A
`define LORC_ADDR_SRC_A 16'h1150
`define LORC_ADDR_SRC_B 16'h1151
`define LORC_ADDR_FUNC 16'h1152
`define LORC_ADDR_TERM_ON 16'h1153
`define LORC_ADDR_TERM_OFF 16'h1154
`define LORC_ADDR_RELAY_ON 16'h1157
`define LORC_ADDR_RELAY_OFF 16'h1158

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define LORC_RST_MODE 16'h0000
`define LORC_RST_SRC 16'h0000
`define LORC_RST_FUNC 16'h0000
`define LORC_RST_DELAY 16'h0000

// --------------------------------------------------------------
// codes and legal limits
// --------------------------------------------------------------
`define LORC_MODE_RISE_STOP 16'h0000
`define LORC_MODE_FALL_STOP 16'h0001
`define LORC_MODE_RISE_NORUN 16'h0002
`define LORC_FUNC_AND 16'h0000
`define LORC_FUNC_OR 16'h0001
`define LORC_FUNC_XOR 16'h0002
`define LORC_SRC_MAX_LOW 16'h0008
`define LORC_SRC_CODE_10 16'h000A
`define LORC_SRC_CODE_43 16'h002B
`define LORC_DELAY_MAX 16'h03E8

// --------------------------------------------------------------
// timing: delay step 0.1 s, clock period 40 ns
// --------------------------------------------------------------
`define LORC_STEP_NS 100000000
`define LORC_CLK_NS 40
`define LORC_STEP_CYCLES (`LORC_STEP_NS / `LORC_CLK_NS)

`endif

// File: rtl/lorc_delay.v
`timescale 1ns/10ps
`default_nettype none

// on/off delay filter: output follows the source only after the
// source has held its new level for the programmed number of steps
module lorc_delay #(
	parameter WIDTH = 16
) (
	input wire clock,
	input wire rst_n,
	input wire step_tick,
	input wire source,
	input wire [WIDTH-1:0] on_steps,
	input wire [WIDTH-1:0] off_steps,
	output reg delayed
);

	reg [WIDTH-1:0] count;
	wire [WIDTH-1:0] limit;

	// rising change uses the on time, falling uses the off time
	assign limit = source ? on_steps : off_steps;

	// ------------------------------------------------------
	// step counter
	// ------------------------------------------------------
	// RULE7 RULE8 RULE9 RULE10 timed change
	// RULE11 restart on bounce
	always @(posedge clock) begin
		if (!rst_n) begin
			count <= {WIDTH{1'b0}};
			delayed <= 1'b0;
		end else if (source == delayed) begin
			count <= {WIDTH{1'b0}}; // source back: restart
		end else if (count >= limit) begin
			count <= {WIDTH{1'b0}};
			delayed <= source;
		end else if (step_tick) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

`default_nettype wire

// File: rtl/lorc_top.v
`timescale 1ns/10ps
`default_nettype none
`include "lorc_defs.vh"

// Operation
// RULE1 - Mode 0: rising clear edge clears a trip and stops a running drive.
// RULE2 - Mode 1: falling clear edge clears a trip and stops a running drive.
// RULE3 - Mode 2: a rising clear edge clears a trip unless the drive runs.
// RULE4 - Mode takes only 0, 1 or 2; the bench master also writes 3, which is refused.
// RULE5 - Two selectors pick status inputs A and B by codes 0-8, 10 and 43.
// RULE6 - The combiner gives A AND B, A OR B or A XOR B for codes 0, 1, 2.
// RULE7 - Terminal turn-on waits a delay of 0 to 1000 steps of 0.1 s.
// RULE8 - Terminal turn-off waits its own delay of 0 to 1000 steps of 0.1 s.
// RULE9 - Relay energizing waits a delay of 0 to 1000 steps of 0.1 s.
// RULE10 - Relay de-energizing has its own delay of 0 to 1000 steps of 0.1 s.
// RULE11 - Each delay restarts on a source change; short pulses are dropped.
// RULE12 - An out-of-range write is refused and the old setting is kept.
module lorc_top #(
	parameter STEP_CYCLES = `LORC_STEP_CYCLES,
	parameter STATUS_W = 44
) (
	input wire clock,
	input wire rst_n,
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [15:0] reg_rdata,
	output reg reg_done,
	output reg reg_error,
	input wire trip_clear_input,
	input wire drive_running,
	input wire [STATUS_W-1:0] status_signals,
	input wire relay_source,
	output reg trip_clear,
	output reg drive_stop,
	output reg logic_output,
	output wire terminal_output,
	output wire relay_output
);

	// ------------------------------------------------------
	// settings
	// ------------------------------------------------------
	reg [15:0] reset_response_mode;
	reg [15:0] combiner_source_a;
	reg [15:0] combiner_source_b;
	reg [15:0] combiner_function;
	reg [15:0] terminal_on_delay;
	reg [15:0] terminal_off_delay;
	reg [15:0] relay_on_delay;
	reg [15:0] relay_off_delay;

	reg [31:0] step_count;
	reg step_tick;
	reg clear_meta;
	reg clear_sync;
	reg clear_last;
	reg next_logic;
	reg addr_known;
	reg value_ok;
	wire clear_rise;
	wire clear_fall;
	wire sel_a;
	wire sel_b;

	// source code legal: 0..8, 10 or 43
	function src_legal;
		input [15:0] code;
		begin
			src_legal = (code <= `LORC_SRC_MAX_LOW) ||
				(code == `LORC_SRC_CODE_10) ||
				(code == `LORC_SRC_CODE_43);
		end
	endfunction

	// pick one status signal by code; codes past the vector read 0
	function pick_status;
		input [15:0] code;
		input [STATUS_W-1:0] bits;
		integer i;
		begin
			pick_status = 1'b0;
			for (i = 0; i < STATUS_W; i = i + 1) begin
				if (code == i[15:0])
					pick_status = bits[i];
			end
		end
	endfunction

	// ------------------------------------------------------
	// address decode and range check
	// ------------------------------------------------------
	// RULE4 mode range
	// RULE12 range check
	always @* begin
		addr_known = 1'b1;
		value_ok = 1'b0;
		case (reg_addr)
		`LORC_ADDR_MODE: begin
			value_ok = reg_wdata <= `LORC_MODE_RISE_NORUN;
		end
		`LORC_ADDR_SRC_A, `LORC_ADDR_SRC_B: begin
			value_ok = src_legal(reg_wdata);
		end
		`LORC_ADDR_FUNC: begin
			value_ok = reg_wdata <= `LORC_FUNC_XOR;
		end
		`LORC_ADDR_TERM_ON, `LORC_ADDR_TERM_OFF,
		`LORC_ADDR_RELAY_ON, `LORC_ADDR_RELAY_OFF: begin
			value_ok = reg_wdata <= `LORC_DELAY_MAX;
		end
		default: begin
			addr_known = 1'b0;
		end
		endcase
	end

	// ------------------------------------------------------
	// register writes
	// ------------------------------------------------------
	// RULE12 refused write keeps value
	always @(posedge clock) begin
		if (!rst_n) begin
			reset_response_mode <= `LORC_RST_MODE;
			combiner_source_a <= `LORC_RST_SRC;
			combiner_source_b <= `LORC_RST_SRC;
			combiner_function <= `LORC_RST_FUNC;
			terminal_on_delay <= `LORC_RST_DELAY;
			terminal_off_delay <= `LORC_RST_DELAY;
			relay_on_delay <= `LORC_RST_DELAY;
			relay_off_delay <= `LORC_RST_DELAY;
		end else if (reg_write && addr_known && value_ok) begin
			case (reg_addr)
			`LORC_ADDR_MODE: reset_response_mode <= reg_wdata;
			`LORC_ADDR_SRC_A: combiner_source_a <= reg_wdata;
			`LORC_ADDR_SRC_B: combiner_source_b <= reg_wdata;
			`LORC_ADDR_FUNC: combiner_function <= reg_wdata;
			`LORC_ADDR_TERM_ON: terminal_on_delay <= reg_wdata;
			`LORC_ADDR_TERM_OFF: terminal_off_delay <= reg_wdata;
			`LORC_ADDR_RELAY_ON: relay_on_delay <= reg_wdata;
			`LORC_ADDR_RELAY_OFF: relay_off_delay <= reg_wdata;
			default: reset_response_mode <= reset_response_mode;
			endcase
		end
	end

	// ------------------------------------------------------
	// read data and access answer
	// ------------------------------------------------------
	// one cycle after the strobe; write has priority over read
	always @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
			reg_done <= 1'b0;
			reg_error <= 1'b0;
		end else begin
			reg_done <= reg_write | reg_read;
			reg_error <= reg_write ? !(addr_known && value_ok) :
				(reg_read && !addr_known);
			if (reg_read && !reg_write) begin
				case (reg_addr)
				`LORC_ADDR_MODE: reg_rdata <= reset_response_mode;
				`LORC_ADDR_SRC_A: reg_rdata <= combiner_source_a;
				`LORC_ADDR_SRC_B: reg_rdata <= combiner_source_b;
				`LORC_ADDR_FUNC: reg_rdata <= combiner_function;
				`LORC_ADDR_TERM_ON: reg_rdata <= terminal_on_delay;
				`LORC_ADDR_TERM_OFF: reg_rdata <= terminal_off_delay;
				`LORC_ADDR_RELAY_ON: reg_rdata <= relay_on_delay;
				`LORC_ADDR_RELAY_OFF: reg_rdata <= relay_off_delay;
				default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------
	// trip-clear input: synchronise and detect edges
	// ------------------------------------------------------
	// the pin is asynchronous, so two flops before any edge logic
	always @(posedge clock) begin
		if (!rst_n) begin
			clear_meta <= 1'b0;
			clear_sync <= 1'b0;
			clear_last <= 1'b0;
		end else begin
			clear_meta <= trip_clear_input;
			clear_sync <= clear_meta;
			clear_last <= clear_sync;
		end
	end

	assign clear_rise = clear_sync && !clear_last;
	assign clear_fall = !clear_sync && clear_last;

	// ------------------------------------------------------
	// reset response by mode
	// ------------------------------------------------------
	always @(posedge clock) begin
		if (!rst_n) begin
			trip_clear <= 1'b0;
			drive_stop <= 1'b0;
		end else begin
			case (reset_response_mode)
			// RULE1 rising edge, stop
			`LORC_MODE_RISE_STOP: begin
				trip_clear <= clear_rise;
				drive_stop <= clear_rise && drive_running;
			end
			// RULE2 falling edge, stop
			`LORC_MODE_FALL_STOP: begin
				trip_clear <= clear_fall;
				drive_stop <= clear_fall && drive_running;
			end
			// RULE3 ignored while running
			`LORC_MODE_RISE_NORUN: begin
				trip_clear <= clear_rise && !drive_running;
				drive_stop <= 1'b0;
			end
			default: begin
				trip_clear <= 1'b0;
				drive_stop <= 1'b0;
			end
			endcase
		end
	end

	// ------------------------------------------------------
	// combiner
	// ------------------------------------------------------
	// RULE5 source selectors
	assign sel_a = pick_status(combiner_source_a, status_signals);
	assign sel_b = pick_status(combiner_source_b, status_signals);

	// RULE6 logic function
	always @* begin
		case (combiner_function)
		`LORC_FUNC_AND: next_logic = sel_a & sel_b;
		`LORC_FUNC_OR: next_logic = sel_a | sel_b;
		`LORC_FUNC_XOR: next_logic = sel_a ^ sel_b;
		default: next_logic = 1'b0;
		endcase
	end

	always @(posedge clock) begin
		if (!rst_n)
			logic_output <= 1'b0;
		else
			logic_output <= next_logic;
	end

	// ------------------------------------------------------
	// 0.1 s step timebase shared by both delays
	// ------------------------------------------------------
	always @(posedge clock) begin
		if (!rst_n) begin
			step_count <= 32'h00000000;
			step_tick <= 1'b0;
		end else if (step_count >= STEP_CYCLES - 1) begin
			step_count <= 32'h00000000;
			step_tick <= 1'b1;
		end else begin
			step_count <= step_count + 32'h00000001;
			step_tick <= 1'b0;
		end
	end

	// ------------------------------------------------------
	// output terminal and relay delays
	// ------------------------------------------------------
	// RULE7 RULE8 terminal delays
	lorc_delay #(.WIDTH(16)) u_terminal (
		.clock(clock),
		.rst_n(rst_n),
		.step_tick(step_tick),
		.source(logic_output),
		.on_steps(terminal_on_delay),
		.off_steps(terminal_off_delay),
		.delayed(terminal_output)
	);

	// RULE9 RULE10 relay delays
	lorc_delay #(.WIDTH(16)) u_relay (
		.clock(clock),
		.rst_n(rst_n),
		.step_tick(step_tick),
		.source(relay_source),
		.on_steps(relay_on_delay),
		.off_steps(relay_off_delay),
		.delayed(relay_output)
	);

endmodule

`default_nettype wire

// File: test/lorc_master.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// network master model
// ----------------------------
module lorc_master (
	input wire logic clock,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_done,
	input wire logic reg_error,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_write,
	output logic reg_read
);
	initial begin
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	// caller picks values
	// one strobe per access; answer taken one edge after it lands
	task automatic access(input logic w, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic [1:0] r);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= w;
		reg_read <= !w;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
		reg_addr <= ~a; // released bus must not look like the last access
		reg_wdata <= ~d;
		@(posedge clock);
		q = reg_rdata;
		r = {reg_done, reg_error};
	endtask
endmodule
`default_nettype wire

// File: test/lorc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// port checks for the bank
// ----------------------------
module lorc_top_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_done,
	input wire logic reg_error,
	input wire logic trip_clear_input,
	input wire logic drive_running,
	input wire logic relay_source,
	input wire logic trip_clear,
	input wire logic drive_stop,
	input wire logic logic_output,
	input wire logic terminal_output,
	input wire logic relay_output
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// decode of the eight settings; anything else is a hole
	wire mapped = reg_addr inside {16'h114A, 16'h1150, 16'h1151, 16'h1152,
		16'h1153, 16'h1154, 16'h1157, 16'h1158};
	wire dly_addr = reg_addr inside {16'h1153, 16'h1154, 16'h1157, 16'h1158};
	property p_answer; (reg_write || reg_read) |=> reg_done; endproperty
	a_answer: assert property (p_answer) else $error("access not answered");
	property p_mode;
		reg_write && reg_addr == 16'h114A && reg_wdata > 16'h0002 |=> reg_error;
	endproperty
	a_mode: assert property (p_mode) else $error("bad mode taken");
	property p_delay;
		reg_write && dly_addr && reg_wdata > 16'h03E8 |=> reg_error;
	endproperty
	a_delay: assert property (p_delay) else $error("bad delay taken");
	property p_hole;
		reg_read && !reg_write && !mapped |=> reg_error && reg_rdata == 16'h0000;
	endproperty
	a_hole: assert property (p_hole) else $error("hole read wrong");
	// the pin passes two sync flops and an edge flop before the pulse
	property p_clear;
		trip_clear |-> $past(trip_clear_input, 3) != $past(trip_clear_input, 4);
	endproperty
	a_clear: assert property (p_clear) else $error("clear without edge");
	property p_stop; drive_stop |-> trip_clear && $past(drive_running); endproperty
	a_stop: assert property (p_stop) else $error("stop while idle");
	property p_relay;
		$changed(relay_output) |-> relay_output == $past(relay_source);
	endproperty
	a_relay: assert property (p_relay) else $error("relay moved alone");
	property p_term;
		$changed(terminal_output) |-> terminal_output == $past(logic_output);
	endproperty
	a_term: assert property (p_term) else $error("terminal moved alone");
	c_stop: cover property (drive_stop);
	c_err: cover property (reg_error);
	c_relay: cover property ($rose(relay_output));
endmodule

bind lorc_top lorc_top_sva lorc_top_sva_inst (.clock(clock), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .reg_done(reg_done),
	.reg_error(reg_error), .trip_clear_input(trip_clear_input),
	.drive_running(drive_running), .relay_source(relay_source),
	.trip_clear(trip_clear), .drive_stop(drive_stop),
	.logic_output(logic_output), .terminal_output(terminal_output),
	.relay_output(relay_output));
`default_nettype wire

// File: test/lorc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// bench for the settings bank
// ----------------------------
module lorc_top_tb;
	localparam int S = 10;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic trip_clear_input = 1'b0;
	logic drive_running = 1'b0;
	logic [43:0] status_signals = 44'h0;
	logic relay_source = 1'b0;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, q, a, b;
	logic reg_write, reg_read, reg_done, reg_error, trip_clear, drive_stop;
	logic logic_output, terminal_output, relay_output;
	logic [1:0] r;
	int num_errors = 0;
	int samples_checked = 0;
	int n_clr = 0;
	int n_stop = 0;
	int cyc = 0;
	int f;
	logic [15:0] addrs [8] = '{16'h114A, 16'h1150, 16'h1151, 16'h1152,
		16'h1153, 16'h1154, 16'h1157, 16'h1158};
	always #20 clock = ~clock;
	lorc_top #(.STEP_CYCLES(S), .STATUS_W(44)) lorc_top_inst (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .reg_done(reg_done), .reg_error(reg_error),
		.trip_clear_input(trip_clear_input), .drive_running(drive_running),
		.status_signals(status_signals), .relay_source(relay_source),
		.trip_clear(trip_clear), .drive_stop(drive_stop),
		.logic_output(logic_output), .terminal_output(terminal_output),
		.relay_output(relay_output));
	lorc_master lorc_master_inst (.clock(clock), .reg_rdata(reg_rdata),
		.reg_done(reg_done), .reg_error(reg_error), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));
	// pulse counters and a hang guard well above the expected run
	always @(posedge clock) begin
		cyc <= cyc + 1;
		n_clr <= n_clr + (trip_clear === 1'b1);
		n_stop <= n_stop + (drive_stop === 1'b1);
		if (cyc == 5000) begin
			num_errors++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [15:0] ad, input logic [15:0] d, input logic e);
		lorc_master_inst.access(1'b1, ad, d, q, r);
		chk(16'(r), {14'h0, 1'b1, e});
	endtask
	task rd(input logic [15:0] ad, input logic [15:0] d, input logic e);
		lorc_master_inst.access(1'b0, ad, 16'h0000, q, r);
		chk(16'(r), {14'h0, 1'b1, e});
		chk(q, d);
	endtask
	function automatic logic [15:0] code(input int i);
		return (i < 9) ? 16'(i) : ((i == 9) ? 16'h000A : 16'h002B);
	endfunction
	function automatic logic comb(input int fn, input logic x, input logic y);
		return (fn == 0) ? (x & y) : ((fn == 1) ? (x | y) : (x ^ y));
	endfunction
	function automatic logic outp(input logic s);
		return s ? relay_output : terminal_output;
	endfunction
	task src(input logic s, input logic v);
		if (s) relay_source <= v;
		else status_signals[0] <= v;
	endtask
	// one rising then one falling pin edge, pulses counted per window
	task trip(input int m, input logic run);
		int c0, s0;
		wr(16'h114A, 16'(m), 1'b0);
		drive_running <= run;
		c0 = n_clr;
		s0 = n_stop;
		trip_clear_input <= 1'b1;
		repeat (8) @(posedge clock);
		chk(16'(n_clr - c0), 16'(m != 1 && !(m == 2 && run)));
		chk(16'(n_stop - s0), 16'(m == 0 && run));
		c0 = n_clr;
		s0 = n_stop;
		trip_clear_input <= 1'b0;
		repeat (8) @(posedge clock);
		chk(16'(n_clr - c0), 16'(m == 1));
		chk(16'(n_stop - s0), 16'(m == 1 && run));
	endtask
	// a short pulse first, then a held level each way
	task dly(input logic s, input int on, input int off);
		wr(s ? 16'h1157 : 16'h1153, 16'(on), 1'b0);
		wr(s ? 16'h1158 : 16'h1154, 16'(off), 1'b0);
		// a long off delay left from earlier tests may still be running
		repeat ((off + 1) * S + 4) @(posedge clock);
		chk(16'(outp(s)), 16'h0000);
		src(s, 1'b1);
		repeat (S) @(posedge clock);
		src(s, 1'b0);
		repeat ((on - 1) * S + 4) @(posedge clock);
		chk(16'(outp(s)), 16'h0000);
		repeat (3 * S) @(posedge clock);
		src(s, 1'b1);
		repeat ((on - 1) * S) @(posedge clock);
		chk(16'(outp(s)), 16'h0000);
		repeat (S + 4) @(posedge clock);
		chk(16'(outp(s)), 16'h0001);
		src(s, 1'b0);
		repeat ((off - 1) * S) @(posedge clock);
		chk(16'(outp(s)), 16'h0001);
		repeat (S + 4) @(posedge clock);
		chk(16'(outp(s)), 16'h0000);
	endtask
	initial begin
		void'($urandom(32'hBF31B737));
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		foreach (addrs[i]) rd(addrs[i], 16'h0000, 1'b0);
		rd(16'h1155, 16'h0000, 1'b1);
		// refused values leave every setting untouched
		wr(16'h114A, 16'h0003, 1'b1);
		wr(16'h1150, 16'h0009, 1'b1);
		wr(16'h1151, 16'h002C, 1'b1);
		wr(16'h1152, 16'h0003, 1'b1);
		wr(16'h1153, 16'h03E9, 1'b1);
		wr(16'h1158, 16'hFFFF, 1'b1);
		foreach (addrs[i]) rd(addrs[i], 16'h0000, 1'b0);
		wr(16'h1154, 16'h03E8, 1'b0);
		rd(16'h1154, 16'h03E8, 1'b0);
		repeat (30) begin
			a = code($urandom % 11);
			b = code($urandom % 11);
			f = $urandom % 3;
			wr(16'h1150, a, 1'b0);
			wr(16'h1151, b, 1'b0);
			wr(16'h1152, 16'(f), 1'b0);
			status_signals <= 44'({$urandom, $urandom});
			rd(16'h1151, b, 1'b0);
			chk(16'(logic_output), 16'(comb(f, status_signals[a],
				status_signals[b])));
		end
		for (int m = 0; m < 3; m++) begin
			trip(m, 1'b0);
			trip(m, 1'b1);
		end
		wr(16'h1150, 16'h0000, 1'b0);
		wr(16'h1151, 16'h0000, 1'b0);
		wr(16'h1152, 16'h0000, 1'b0);
		status_signals <= 44'h0;
		dly(1'b0, 3, 3);
		dly(1'b1, 4, 2);
		end_of_test();
	end
endmodule
`default_nettype wire
